/* core/adcc_pkg.sv */
// Package: constants, types and register map of the converter control block
package adcc_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_INPUT_SELECT  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_A     = 8'h04;
  localparam logic [7:0] ADDR_CONTROL_B     = 8'h08;
  localparam logic [7:0] ADDR_RESULT_LOW    = 8'h0c;
  localparam logic [7:0] ADDR_RESULT_HIGH   = 8'h10;
  localparam logic [7:0] ADDR_POWER_REDUCE  = 8'h14;

  // ==========================================================
  // Field positions
  localparam int INSEL_REF_POS    = 6;   // [7:6]
  localparam int INSEL_LEFT_POS   = 5;
  localparam int INSEL_CHAN_POS   = 0;   // [3:0]
  localparam int CTLA_ENABLE_POS  = 7;
  localparam int CTLA_START_POS   = 6;
  localparam int CTLA_AUTO_POS    = 5;
  localparam int CTLA_FLAG_POS    = 4;
  localparam int CTLA_PRESC_POS   = 0;   // [2:0]
  localparam int CTLB_TRIG_POS    = 0;   // [2:0]
  localparam int PWR_REDUCE_POS   = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_CONTROL_A    = 8'h00;
  localparam logic [2:0] RST_TRIGGER_SEL  = 3'h0;
  localparam logic       RST_POWER_REDUCE = 1'b0;

  // ==========================================================
  // Conversion timing in converter clock cycles
  localparam logic [4:0] CONV_NORMAL_CYC  = 5'd13;
  localparam logic [4:0] CONV_FIRST_CYC   = 5'd25;
  localparam logic [4:0] SAMPLE_NORMAL    = 5'd1;
  localparam logic [4:0] SAMPLE_FIRST     = 5'd13;
  localparam logic [4:0] RESULT_BITS      = 5'd10;

  // ==========================================================
  // Channel and reference codes
  localparam logic [3:0] CHAN_BANDGAP     = 4'he;
  localparam logic [3:0] CHAN_GROUND      = 4'hf;
  localparam logic [1:0] REF_EXTERNAL     = 2'h0;
  localparam logic [1:0] REF_SUPPLY       = 2'h1;
  localparam logic [1:0] REF_INTERNAL     = 2'h3;

  // ==========================================================
  // Trigger sources
  typedef enum logic [2:0] {
    TRIG_FREE_RUN   = 3'b000,
    TRIG_COMPARATOR = 3'b001,
    TRIG_EXT_INT0   = 3'b010,
    TRIG_T0_CMPA    = 3'b011,
    TRIG_T0_OVF     = 3'b100,
    TRIG_T1_CMPB    = 3'b101,
    TRIG_T1_OVF     = 3'b110,
    TRIG_T1_CAPT    = 3'b111
  } adcc_trig_type;

  // Conversion sequencer states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adcc_state_type;

  // Controls to the analog macro
  typedef struct packed {
    logic       enable;
    logic [3:0] channel;
    logic [1:0] refSel;
    logic       sample;
    logic [9:0] trialCode;
  } adcc_analog_type;

endpackage

/* core/adcc_conversion_control.sv */
// Converter control: APB registers, prescaler, triggering and SAR sequencing
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module adcc_conversion_control
  import adcc_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            clkEn,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [6:0]      trigFlags,
  input  wire logic            cmpIn,
  output adcc_analog_type      analogCtl,
  output logic                 convDone
);

  // ==========================================================
  // Registers
  logic [7:0]      inSel_q;
  logic            enable_q;
  logic            autoTrig_q;
  logic            flag_q;
  logic [2:0]      presc_q;
  adcc_trig_type   trigSel_q;
  logic            pwrReduce_q;
  logic            startReq_q;
  adcc_state_type  state_q;
  logic [4:0]      cycCnt_q;
  logic            convFirst_q;
  logic            firstPend_q;
  logic [9:0]      sar_q;
  logic [9:0]      result_q;
  logic            lock_q;
  logic [6:0]      prescCnt_q;
  logic [3:0]      chanLat_q;
  logic [1:0]      refLat_q;
  logic            prevTrig_q;
  logic [6:0]      trigMeta_q;
  logic [6:0]      trigSync_q;
  logic            cmpMeta_q;
  logic            cmpSync_q;
  logic [31:0]     prdata_q;
  adcc_analog_type analog_q;
  logic            convDone_q;

  // ==========================================================
  // APB decode
  wire setupPh  = psel & ~penable;
  wire accessPh = psel & penable & clkEn;
  wire selIn    = (paddr == ADDR_INPUT_SELECT);
  wire selCa    = (paddr == ADDR_CONTROL_A);
  wire selCb    = (paddr == ADDR_CONTROL_B);
  wire selLo    = (paddr == ADDR_RESULT_LOW);
  wire selHi    = (paddr == ADDR_RESULT_HIGH);
  wire selPr    = (paddr == ADDR_POWER_REDUCE);
  wire mapped   = selIn | selCa | selCb | selLo | selHi | selPr;
  wire wrIn     = accessPh & pwrite & selIn;
  wire wrCa     = accessPh & pwrite & selCa;
  wire wrCb     = accessPh & pwrite & selCb;
  wire wrPr     = accessPh & pwrite & selPr;
  wire rdLo     = accessPh & ~pwrite & selLo;
  wire rdHi     = accessPh & ~pwrite & selHi;

  // No wait states; a frozen block stalls the access
  assign pready  = clkEn;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  // ==========================================================
  // Derived controls
  wire       leftAdj  = inSel_q[INSEL_LEFT_POS];
  wire       enabled  = enable_q & ~pwrReduce_q;
  wire       busy     = (state_q == ST_CONV);
  wire       freeRun  = autoTrig_q & (trigSel_q == TRIG_FREE_RUN);
  wire       startBit = startReq_q | busy;
  wire [4:0] convLen  = convFirst_q ? CONV_FIRST_CYC : CONV_NORMAL_CYC;
  wire [4:0] sampEnd  = convFirst_q ? SAMPLE_FIRST : SAMPLE_NORMAL;

  // Result formatting by justification
  wire [7:0] resLo = leftAdj ? {result_q[1:0], 6'h00} : result_q[7:0];
  wire [7:0] resHi = leftAdj ? result_q[9:2] : {6'h00, result_q[9:8]};

  // Read mux, captured in the setup phase so prdata is a flop
  wire [7:0] rdByte = selIn ? inSel_q :
                      selCa ? {enable_q, startBit, autoTrig_q, flag_q, 1'b0, presc_q} :
                      selCb ? {5'h00, trigSel_q} :
                      selLo ? resLo :
                      selHi ? resHi :
                      selPr ? {7'h00, pwrReduce_q} : 8'h00;

  // ==========================================================
  // Prescaler: divide by two to the field, zero behaves as one
  wire [2:0] pscEff  = (presc_q == 3'h0) ? 3'h1 : presc_q;
  wire [7:0] divFull = (8'h01 << pscEff) - 8'h01;
  wire [6:0] divLast = divFull[6:0];
  wire       tick    = enabled & (prescCnt_q == divLast);

  // ==========================================================
  // Trigger selection and edge detect
  wire [2:0] trigIdx = 3'(trigSel_q - 3'h1);
  // Source flags arrive set whatever their own interrupt enables are
  wire selTrig = (trigSel_q == TRIG_FREE_RUN) ? 1'b0 : trigSync_q[trigIdx];
  // Free running has no edge of its own; a held flag never retriggers
  wire trigEdge = autoTrig_q & enabled & selTrig & ~prevTrig_q;
  // Edges while busy are dropped, nothing is queued
  wire trigStart = trigEdge & ~busy;

  // ==========================================================
  // Conversion sequencing
  wire swStart  = wrCa & pwdata[CTLA_START_POS] & pwdata[CTLA_ENABLE_POS] & ~pwrReduce_q;
  wire swBegin  = tick & startReq_q & ~busy;
  wire done     = busy & tick & (cycCnt_q == convLen - 5'd1);
  // Own flag as source: restart on completion, flag state irrelevant
  wire restart  = done & freeRun;
  wire startNow = swBegin | trigStart | restart;
  // Bit decisions in the ten cycles before the last
  wire [4:0] stepBase = convLen - RESULT_BITS - 5'd1;
  wire [4:0] stepOffs = 5'(cycCnt_q - stepBase);
  // Trial code stands the whole step so the comparator settles before the tick
  wire       stepWin  = busy & (cycCnt_q >= stepBase) & (cycCnt_q <= convLen - 5'd2);
  wire       stepping = stepWin & tick;
  wire [3:0] bitPos   = 4'(5'd9 - stepOffs);
  wire [9:0] trial    = sar_q | (10'h001 << bitPos);
  wire       resWrite = done & ~lock_q & ~rdLo;

  // Input pin synchronisers, one per trigger flag
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_trigSync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          trigMeta_q[gi] <= 1'b0;
          trigSync_q[gi] <= 1'b0;
        end else if (clkEn) begin
          trigMeta_q[gi] <= trigFlags[gi];
          trigSync_q[gi] <= trigMeta_q[gi];
        end
      end
    end
  endgenerate

  // Comparator synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmpMeta_q <= 1'b0;
      cmpSync_q <= 1'b0;
    end else if (clkEn) begin
      cmpMeta_q <= cmpIn;
      cmpSync_q <= cmpMeta_q;
    end
  end

  // Input select register, control B, power reduction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inSel_q     <= RST_INPUT_SELECT;
      trigSel_q   <= adcc_trig_type'(RST_TRIGGER_SEL);
      pwrReduce_q <= RST_POWER_REDUCE;
    end else if (clkEn) begin
      if (wrIn) inSel_q <= pwdata[7:0];
      if (wrCb) trigSel_q <= adcc_trig_type'(pwdata[CTLB_TRIG_POS +: 3]);
      if (wrPr) pwrReduce_q <= pwdata[PWR_REDUCE_POS];
    end
  end

  // Control A plain fields
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable_q   <= RST_CONTROL_A[CTLA_ENABLE_POS];
      autoTrig_q <= RST_CONTROL_A[CTLA_AUTO_POS];
      presc_q    <= RST_CONTROL_A[CTLA_PRESC_POS +: 3];
    end else if (clkEn && wrCa) begin
      enable_q   <= pwdata[CTLA_ENABLE_POS];
      autoTrig_q <= pwdata[CTLA_AUTO_POS];
      presc_q    <= pwdata[CTLA_PRESC_POS +: 3];
    end
  end

  // Completion flag: set wins over a write-one clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (clkEn) begin
      if (done) flag_q <= 1'b1;
      else if (wrCa && pwdata[CTLA_FLAG_POS]) flag_q <= 1'b0;
    end
  end

  // Pending software start, dropped when the converter goes off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      startReq_q <= 1'b0;
    end else if (clkEn) begin
      if (!enabled) startReq_q <= 1'b0;
      else if (swStart) startReq_q <= 1'b1;
      else if (startNow) startReq_q <= 1'b0;
    end
  end

  // Prescaler: held at zero while off, restarted by a trigger
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescCnt_q <= 7'h00;
    end else if (clkEn) begin
      if (!enabled || trigStart || tick) prescCnt_q <= 7'h00;
      else prescCnt_q <= 7'(prescCnt_q + 7'h01);
    end
  end

  // Sequencer state; completion returns to idle unless free running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          if (startNow) state_q <= ST_CONV;
        end
        ST_CONV: begin
          if (!enabled) state_q <= ST_IDLE;
          else if (done && !restart) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Cycle count within a conversion and first-conversion tracking
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cycCnt_q    <= 5'h00;
      convFirst_q <= 1'b0;
      firstPend_q <= 1'b1;
    end else if (clkEn) begin
      if (!enabled) firstPend_q <= 1'b1;
      else if (startNow) firstPend_q <= 1'b0;
      if (startNow) begin
        cycCnt_q    <= 5'h00;
        convFirst_q <= firstPend_q;
      end else if (busy && tick) begin
        cycCnt_q <= 5'(cycCnt_q + 5'h01);
      end
    end
  end

  // Successive approximation register, MSB first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sar_q <= 10'h000;
    end else if (clkEn) begin
      if (startNow) sar_q <= 10'h000;
      else if (stepping && cmpSync_q) sar_q <= trial;
    end
  end

  // Result bytes: a blocked completion is simply dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_q <= 10'h000;
    end else if (clkEn && resWrite) begin
      result_q <= sar_q;
    end
  end

  // Read-order lock between low and high byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (clkEn) begin
      if (rdHi) lock_q <= 1'b0;
      else if (rdLo) lock_q <= 1'b1;
    end
  end

  // Channel and reference latch: frozen during a conversion, only when on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chanLat_q <= CHAN_GROUND;
      refLat_q  <= REF_EXTERNAL;
    end else if (clkEn && enabled && (!busy || done)) begin
      chanLat_q <= inSel_q[INSEL_CHAN_POS +: 4];
      refLat_q  <= inSel_q[INSEL_REF_POS +: 2];
    end
  end

  // Trigger history for the edge detect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevTrig_q <= 1'b0;
    end else if (clkEn) begin
      prevTrig_q <= selTrig;
    end
  end

  // Analog controls and read data as flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_q   <= '0;
      prdata_q   <= 32'h0000_0000;
      convDone_q <= 1'b0;
    end else if (clkEn) begin
      analog_q.enable    <= enabled;
      analog_q.channel   <= chanLat_q;
      analog_q.refSel    <= refLat_q;
      analog_q.sample    <= busy & (cycCnt_q <= sampEnd);
      analog_q.trialCode <= stepWin ? trial : sar_q;
      convDone_q         <= done;
      if (setupPh) prdata_q <= {24'h00_0000, rdByte};
    end
  end

  assign analogCtl = analog_q;
  assign convDone  = convDone_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_BUSY_READS_START: assert property (busy |-> startBit)
    else $error("start bit low during a conversion");
  AST_LOW_READ_LOCKS: assert property (rdLo && !rdHi |=> lock_q)
    else $error("low byte read did not lock results");
  AST_HIGH_READ_UNLOCKS: assert property (rdHi |=> !lock_q)
    else $error("high byte read did not release lock");
  AST_LOCKED_KEEPS_RESULT: assert property (lock_q && done |=> $stable(result_q))
    else $error("result changed while locked");
  AST_DONE_SETS_FLAG: assert property (clkEn && done |=> flag_q)
    else $error("completion flag not set");
  AST_SINGLE_CLEARS_START: assert property (clkEn && done && !freeRun && !swStart |=> !startBit)
    else $error("start bit not cleared at completion");
  AST_FREE_RUN_RESTARTS: assert property (clkEn && done && freeRun && enabled |=> busy && cycCnt_q == 5'h00)
    else $error("free running did not restart");
  AST_EDGE_IGNORED_BUSY: assert property (clkEn && busy && trigEdge && !done
                                          |=> busy && cycCnt_q == 5'($past(cycCnt_q) + 5'($past(tick))))
    else $error("trigger edge disturbed a running conversion");
  AST_CHANNEL_HELD: assert property (clkEn && busy && !done && enabled |=> $stable(chanLat_q))
    else $error("channel changed during a conversion");
  AST_PRESCALER_OFF: assert property (clkEn && !enabled |=> prescCnt_q == 7'h00)
    else $error("prescaler running while disabled");
  AST_CONV_LENGTH: assert property (busy |-> cycCnt_q < convLen)
    else $error("conversion ran past its length");

  // Start and trigger checks
  AST_START_NEEDS_POWER: assert property (clkEn && wrCa && pwdata[CTLA_START_POS] && pwrReduce_q |=> !startBit)
    else $error("start accepted while powered down");
  AST_TRIGGER_STARTS: assert property (clkEn && trigStart |=> busy && prescCnt_q == 7'h00 && cycCnt_q == 5'h00)
    else $error("trigger edge did not restart prescaler and conversion");
  AST_HELD_TRIGGER_IDLE: assert property (clkEn && done && !freeRun && autoTrig_q && selTrig |=> !busy ##1 !busy)
    else $error("held trigger started a conversion");
  AST_AUTO_OFF_IDLE: assert property (clkEn && !autoTrig_q && !startReq_q && !busy |=> !busy)
    else $error("conversion started with auto trigger off");

  // Sequencing, result and power checks
  AST_FIRST_CONV_LONG: assert property (clkEn && startNow && firstPend_q |=> convFirst_q && convLen == CONV_FIRST_CYC)
    else $error("first conversion after enable not lengthened");
  AST_DISABLED_ANALOG_OFF: assert property (clkEn && !enabled |=> !analog_q.enable && !busy)
    else $error("analog path active while disabled");
  AST_START_CLEARS_SAR: assert property (clkEn && startNow |=> busy && sar_q == 10'h000)
    else $error("approximation register not cleared at start");
  AST_RESULT_WRITTEN: assert property (clkEn && resWrite |=> result_q == $past(sar_q))
    else $error("completion did not write the result");
  AST_DONE_PULSE: assert property (clkEn && done |=> convDone)
    else $error("completion pulse missing");
  AST_FLAG_CLEARS: assert property (clkEn && wrCa && pwdata[CTLA_FLAG_POS] && !done |=> !flag_q)
    else $error("completion flag not cleared by write one");

endmodule

/* tb/adcc_analog_model.sv */
// Behavioural analog macro: input mux, sample-and-hold and comparator
`timescale 1ns/10ps
module adcc_analog_model
  import adcc_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire adcc_analog_type analogCtl,
  input  wire logic [9:0]      vinTab [16],
  output logic                 cmpIn
);
  logic [9:0] held = 10'h000;
  logic       junk = 1'h0;

  // ==========================================================
  // Sample the selected input while the sample strobe is high
  always @(posedge sys_clk) begin
    junk <= ~junk;
    if (analogCtl.enable && analogCtl.sample) begin
      held <= vinTab[analogCtl.channel];
    end
  end

  // Powered down the comparator gives noise, never a stale decision
  assign cmpIn = analogCtl.enable ? (held >= analogCtl.trialCode) : junk;
endmodule

/* tb/tb.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/10ps
module tb
  import adcc_pkg::*;
;
  logic            sys_clk = 1'h0;
  logic            rst = 1'h1;
  logic            psel = 1'h0;
  logic            penable = 1'h0;
  logic            pwrite = 1'h0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [6:0]      trigFlags = 7'h00;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            cmpIn;
  logic            convDone;
  adcc_analog_type analogCtl;
  logic [9:0]      vinTab [16];
  logic [31:0]     seed = 32'h17;
  logic [32:0]     expQ [$];
  int              bad_count = 0;
  int              cmp_count = 0;
  int              doneCnt = 0;
  int              c0;
  localparam logic [3:0] CHS [5] = '{4'h0, 4'h3, 4'h7, CHAN_BANDGAP, CHAN_GROUND};
  localparam logic [1:0] REFS [3] = '{REF_EXTERNAL, REF_SUPPLY, REF_INTERNAL};

  always #10 sys_clk = ~sys_clk;

  adcc_conversion_control i_dut (
    .sys_clk(sys_clk), .rst(rst), .clkEn(1'h1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigFlags(trigFlags), .cmpIn(cmpIn), .analogCtl(analogCtl), .convDone(convDone));

  adcc_analog_model i_ana (.sys_clk(sys_clk), .analogCtl(analogCtl), .vinTab(vinTab), .cmpIn(cmpIn));

  // ==========================================================
  // Checking, counting and the verdict
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Read results are compared at the access edge, oldest note first
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && expQ.size() > 0) begin
      chk({pslverr, prdata}, expQ.pop_front());
    end
    if (convDone === 1'h1) begin
      doneCnt <= doneCnt + 1;
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ==========================================================
  // APB master: request held until pready is seen high
  task apb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [32:0] ex);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    if (!w) expQ.push_back(ex);
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'h1, d, 33'h0);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] ex);
    apb(a, 1'h0, 8'h00, ex);
  endtask

  task wait_done();
    int n;
    n = 0;
    c0 = doneCnt;
    while (doneCnt == c0 && n < 800) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 800) begin
      bad_count++;
      $display("ERROR t=%0t no completion", $time);
      tally_and_finish();
    end
  endtask

  // One software conversion; channel is changed once it is under way
  task conv(input logic [3:0] ch, input logic [3:0] chNext, input logic left);
    wr(ADDR_INPUT_SELECT, {REF_SUPPLY, left, 1'h0, ch});
    wr(ADDR_CONTROL_A, 8'h93);
    wr(ADDR_CONTROL_A, 8'hc3);
    rd(ADDR_CONTROL_A, 33'hc3);
    repeat (16) @(posedge sys_clk);
    wr(ADDR_INPUT_SELECT, {REF_SUPPLY, left, 1'h0, chNext});
    wait_done();
    rd(ADDR_CONTROL_A, 33'h93);
  endtask

  function automatic logic [15:0] packRes(input logic [9:0] v, input logic left);
    return left ? {v, 6'h00} : {6'h00, v};
  endfunction

  task readRes(input logic [9:0] v, input logic left);
    logic [15:0] r;
    r = packRes(v, left);
    rd(ADDR_RESULT_LOW, {25'h0, r[7:0]});
    rd(ADDR_RESULT_HIGH, {25'h0, r[15:8]});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] t;
    logic [15:0] lk;
    for (int i = 0; i < 16; i++) begin
      t = xs();
      vinTab[i] = t[9:0];
    end
    vinTab[15] = 10'h000;
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    rd(ADDR_INPUT_SELECT, {25'h0, RST_INPUT_SELECT});
    rd(ADDR_CONTROL_A, {25'h0, RST_CONTROL_A});
    rd(ADDR_CONTROL_B, {30'h0, RST_TRIGGER_SEL});
    rd(ADDR_POWER_REDUCE, {32'h0, RST_POWER_REDUCE});
    rd(8'h18, {1'h1, 32'h0});
    wr(ADDR_INPUT_SELECT, {REF_INTERNAL, 2'h0, 4'h3});
    repeat (4) @(posedge sys_clk);
    chk({28'h0, analogCtl.enable, analogCtl.channel}, {28'h0, 1'h0, CHAN_GROUND});
    $display("reset and map test done");
    for (int i = 0; i < 5; i++) begin
      conv(CHS[i], CHS[i], 1'h0);
      readRes(vinTab[CHS[i]], 1'h0);
    end
    conv(4'h2, 4'h6, 1'h1);
    readRes(vinTab[2], 1'h1);
    $display("single conversion test done");
    // Low read locks; a second result is lost until the high read
    lk = packRes(vinTab[4], 1'h1);
    conv(4'h4, 4'h4, 1'h1);
    rd(ADDR_RESULT_LOW, {25'h0, lk[7:0]});
    conv(4'h5, 4'h5, 1'h1);
    rd(ADDR_RESULT_HIGH, {25'h0, lk[15:8]});
    conv(4'h5, 4'h5, 1'h1);
    readRes(vinTab[5], 1'h1);
    $display("result lock test done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_INPUT_SELECT, {REFS[i], 2'h0, 4'h1});
      repeat (4) @(posedge sys_clk);
      chk({31'h0, analogCtl.refSel}, {31'h0, REFS[i]});
    end
    // Auto trigger disabled: an edge must do nothing
    wr(ADDR_CONTROL_B, 8'h01);
    c0 = doneCnt;
    trigFlags[0] <= 1'h1;
    repeat (20) @(posedge sys_clk);
    trigFlags[0] <= 1'h0;
    repeat (300) @(posedge sys_clk);
    chk(33'(doneCnt - c0), 33'h0);
    for (int k = 1; k < 8; k++) begin
      wr(ADDR_CONTROL_B, 8'(k));
      wr(ADDR_CONTROL_A, 8'hb3);
      c0 = doneCnt;
      trigFlags[k-1] <= 1'h1;
      repeat (30) @(posedge sys_clk);
      trigFlags[k-1] <= 1'h0;
      repeat (5) @(posedge sys_clk);
      trigFlags[k-1] <= 1'h1;
      repeat (400) @(posedge sys_clk);
      chk(33'(doneCnt - c0), 33'h1);
      trigFlags[k-1] <= 1'h0;
      repeat (10) @(posedge sys_clk);
    end
    wr(ADDR_CONTROL_A, 8'hf3);
    wait_done();
    rd(ADDR_CONTROL_A, 33'hb3);
    $display("auto trigger test done");
    wr(ADDR_CONTROL_B, 8'h00);
    wr(ADDR_CONTROL_A, 8'hb3);
    c0 = doneCnt;
    repeat (300) @(posedge sys_clk);
    chk(33'(doneCnt - c0), 33'h0);
    wr(ADDR_CONTROL_A, 8'hf3);
    repeat (700) @(posedge sys_clk);
    chk(33'(doneCnt - c0), 33'h6);
    rd(ADDR_CONTROL_A, 33'hf3);
    wr(ADDR_CONTROL_A, 8'h93);
    repeat (300) @(posedge sys_clk);
    rd(ADDR_CONTROL_A, 33'h93);
    $display("free running test done");
    wr(ADDR_POWER_REDUCE, 8'h01);
    rd(ADDR_POWER_REDUCE, 33'h1);
    wr(ADDR_CONTROL_A, 8'h93);
    c0 = doneCnt;
    wr(ADDR_CONTROL_A, 8'hc3);
    repeat (300) @(posedge sys_clk);
    chk(33'(doneCnt - c0), 33'h0);
    rd(ADDR_CONTROL_A, 33'h83);
    wr(ADDR_POWER_REDUCE, 8'h00);
    wr(ADDR_CONTROL_A, 8'h03);
    repeat (4) @(posedge sys_clk);
    chk({32'h0, analogCtl.enable}, 33'h0);
    $display("power and disable test done");
    tally_and_finish();
  end
endmodule
